//--- core/flash_check_regs.vh
// Constants for the flash program/erase parameter checker.
// Assumes inclusion by bare name from the core files.
`ifndef FLASH_CHECK_REGS_VH
`define FLASH_CHECK_REGS_VH
`define RES_OVERALL_FAIL 0
`define RES_DEST_ADDR 1
`define RES_SRC_DATA_ADDR 2
`define RES_ERASE_BLOCK 3
`define RES_KEY 4
`define RES_EXEC 5
`define RES_MODE 6
`define KEY_GOOD 8'h5A
`define ARRAY_USER_BOOT 8'hAA
`define BLOCK_LAST 8'h0B
`define ALIGN_BITS 7
`define RESULT_RESET 32'h00000000
`define FLASH_BASE_DEF 32'h00000000
`define FLASH_SIZE_DEF 32'h00040000
`endif

//--- core/flash_addr_check.v
// Address and key checks for a programming request.
// Assumes all inputs are stable on the checked cycle.
`timescale 1ns/1ps
`include "flash_check_regs.vh"
module flash_addr_check #(
	parameter [31:0] FLASH_BASE = 32'h00000000,
	parameter [31:0] FLASH_SIZE = 32'h00040000
) (
	input wire [31:0] src_addr,
	input wire [31:0] dst_addr,
	input wire [7:0] key,
	output wire src_err,
	output wire dst_err,
	output wire key_err
);
	function in_flash;
		input [31:0] a;
		begin
			in_flash = (a >= FLASH_BASE) && ((a - FLASH_BASE) < FLASH_SIZE);
		end
	endfunction

	assign src_err = in_flash(src_addr);
	assign dst_err = !in_flash(dst_addr) || (dst_addr[6:0] != 7'h00);
	assign key_err = (key != `KEY_GOOD);
endmodule // flash_addr_check

//--- core/flash_prog_erase_param_check.v
// Parameter checking and result word for flash program and erase calls.
// Assumes the CPU presents parameters with a one-cycle start strobe;
// the cell sequencer reports completion and failure on its own ports.
`timescale 1ns/1ps
`include "flash_check_regs.vh"
// Contract
// - Bit 0 reports overall pass or fail.
// - Bit 5 flags unerased target or altered registers.
// - User boot array selected means program error.
// - Bit 4 flags key other than 5A.
// - Bit 2 flags source address inside flash.
// - Bit 1 flags destination outside flash.
// - Bit 1 flags destination not 128-byte aligned.
// - Block number taken from bits 7 to 0.
// - Block above 0B flags error, no erase.
// - Bit 6 flags write pin low or protect.
module flash_prog_erase_param_check #(
	parameter [31:0] FLASH_BASE = `FLASH_BASE_DEF,
	parameter [31:0] FLASH_SIZE = `FLASH_SIZE_DEF
) (
	input wire CLK,
	input wire SRST,
	input wire PROG_START,
	input wire ERASE_START,
	input wire [31:0] SRC_DATA_ADDR,
	input wire [31:0] DEST_ADDR,
	input wire [31:0] ERASE_BLOCK_SELECT_PARAM,
	input wire [7:0] KEY_REGISTER,
	input wire [7:0] ARRAY_SELECT_REG,
	input wire FLASH_WRITE_ENABLE_PIN,
	input wire FLASH_ERROR_PROTECT_FLAG,
	input wire CELL_DONE,
	input wire CELL_FAIL,
	input wire REG_ALTERED,
	output reg [31:0] PASS_FAIL_RESULT,
	output reg RESULT_VALID,
	output reg BUSY,
	output reg CELL_PROG_GO,
	output reg CELL_ERASE_GO,
	output reg [3:0] ERASE_BLOCK_NUMBER
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_PROG = 3'b010;
	localparam [2:0] ST_ERASE = 3'b100;

	// Pin is asynchronous: three stages, change accepted when last two agree
	reg [2:0] fwe_sync_r;
	reg fwe_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [31:0] result_nxt;
	reg valid_nxt;
	reg busy_nxt;
	reg prog_go_nxt;
	reg erase_go_nxt;
	reg [3:0] block_nxt;
	wire src_err;
	wire dst_err;
	wire key_err;
	wire mode_err;
	wire boot_sel;
	wire block_err;
	wire prog_fault;
	wire erase_fault;
	wire [7:0] block_num;

	flash_addr_check #(
		.FLASH_BASE(FLASH_BASE),
		.FLASH_SIZE(FLASH_SIZE)
	) u_addr_check (
		.src_addr(SRC_DATA_ADDR),
		.dst_addr(DEST_ADDR),
		.key(KEY_REGISTER),
		.src_err(src_err),
		.dst_err(dst_err),
		.key_err(key_err)
	);

	// Reset parks the stages at pin-low, so mode error reads set until the pin is seen
	always @(posedge CLK) begin
		if (SRST) begin
			fwe_sync_r <= 3'h0;
		end else begin
			fwe_sync_r <= {fwe_sync_r[1:0], FLASH_WRITE_ENABLE_PIN};
		end
	end

	// Filtered level only moves when the last two stages agree
	always @(posedge CLK) begin
		if (SRST) begin
			fwe_r <= 1'b0;
		end else if (fwe_sync_r[1] == fwe_sync_r[2]) begin
			fwe_r <= fwe_sync_r[2];
		end
	end

	assign mode_err = !fwe_r || FLASH_ERROR_PROTECT_FLAG;
	assign boot_sel = (ARRAY_SELECT_REG == `ARRAY_USER_BOOT);
	assign block_num = ERASE_BLOCK_SELECT_PARAM[7:0];
	assign block_err = (block_num > `BLOCK_LAST);
	assign prog_fault = mode_err || key_err || src_err || dst_err || boot_sel;
	assign erase_fault = mode_err || key_err || block_err || boot_sel;

	// Builds a result word; unused bits stay zero and any error sets fail
	function [31:0] pack;
		input md;
		input ee;
		input fk;
		input eb;
		input wd;
		input wa;
		reg [31:0] w;
		begin
			w = `RESULT_RESET;
			w[`RES_MODE] = md;
			w[`RES_EXEC] = ee;
			w[`RES_KEY] = fk;
			w[`RES_ERASE_BLOCK] = eb;
			w[`RES_SRC_DATA_ADDR] = wd;
			w[`RES_DEST_ADDR] = wa;
			w[`RES_OVERALL_FAIL] = md | ee | fk | eb | wd | wa;
			pack = w;
		end
	endfunction

	// Next state: a failed check never leaves idle
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (PROG_START) begin
					if (!prog_fault) begin
						state_nxt = ST_PROG;
					end
				end else if (ERASE_START) begin
					if (!erase_fault) begin
						state_nxt = ST_ERASE;
					end
				end
			end
			ST_PROG: begin
				if (CELL_DONE) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_ERASE: begin
				if (CELL_DONE) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		busy_nxt = (state_nxt != ST_IDLE);
	end

	// Result word and its valid pulse
	always @* begin
		result_nxt = PASS_FAIL_RESULT;
		valid_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (PROG_START && prog_fault) begin
					// Boot array selection is reported as an execution error
					result_nxt = pack(
						mode_err,
						boot_sel,
						key_err,
						1'b0,
						src_err,
						dst_err
					);
					valid_nxt = 1'b1;
				end else if (!PROG_START && ERASE_START && erase_fault) begin
					result_nxt = pack(
						mode_err,
						boot_sel,
						key_err,
						block_err,
						1'b0,
						1'b0
					);
					valid_nxt = 1'b1;
				end
			end
			ST_PROG, ST_ERASE: begin
				if (CELL_DONE) begin
					// Failed cell write or altered registers both land in bit 5
					result_nxt = pack(
						1'b0,
						CELL_FAIL | REG_ALTERED,
						1'b0,
						1'b0,
						1'b0,
						1'b0
					);
					valid_nxt = 1'b1;
				end
			end
			default: begin
				valid_nxt = 1'b0;
			end
		endcase
	end

	// Cell start pulses and the accepted block number
	always @* begin
		prog_go_nxt = 1'b0;
		erase_go_nxt = 1'b0;
		block_nxt = ERASE_BLOCK_NUMBER;
		case (state_r)
			ST_IDLE: begin
				if (PROG_START) begin
					prog_go_nxt = !prog_fault;
				end else if (ERASE_START && !erase_fault) begin
					// Only the low nibble can name a legal block
					block_nxt = block_num[3:0];
					erase_go_nxt = 1'b1;
				end
			end
			ST_PROG, ST_ERASE: begin
				block_nxt = ERASE_BLOCK_NUMBER;
			end
			default: begin
				prog_go_nxt = 1'b0;
			end
		endcase
	end

	// One-hot state, back to idle on reset
	always @(posedge CLK) begin
		if (SRST) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Result holds until the next answer
	always @(posedge CLK) begin
		if (SRST) begin
			PASS_FAIL_RESULT <= `RESULT_RESET;
		end else begin
			PASS_FAIL_RESULT <= result_nxt;
		end
	end

	// Valid is a one-cycle pulse
	always @(posedge CLK) begin
		if (SRST) begin
			RESULT_VALID <= 1'b0;
		end else begin
			RESULT_VALID <= valid_nxt;
		end
	end

	// Busy tracks the state so starts during an operation are refused
	always @(posedge CLK) begin
		if (SRST) begin
			BUSY <= 1'b0;
		end else begin
			BUSY <= busy_nxt;
		end
	end

	// Program start pulse to the cell sequencer
	always @(posedge CLK) begin
		if (SRST) begin
			CELL_PROG_GO <= 1'b0;
		end else begin
			CELL_PROG_GO <= prog_go_nxt;
		end
	end

	// Erase start pulse to the cell sequencer
	always @(posedge CLK) begin
		if (SRST) begin
			CELL_ERASE_GO <= 1'b0;
		end else begin
			CELL_ERASE_GO <= erase_go_nxt;
		end
	end

	// Block number kept for the running erase
	always @(posedge CLK) begin
		if (SRST) begin
			ERASE_BLOCK_NUMBER <= 4'h0;
		end else begin
			ERASE_BLOCK_NUMBER <= block_nxt;
		end
	end
endmodule // flash_prog_erase_param_check

//--- tb/flash_param_checker.sv
// Port-level assertions on the flash parameter checker.
// Assumes the flash area starts at address 0.
`timescale 1ns/1ps
module flash_param_checker #(parameter [31:0] FLASH_SIZE = 32'h00040000) (
	input wire CLK, input wire SRST, input wire PROG_START, input wire ERASE_START, input wire BUSY,
	input wire [31:0] SRC_DATA_ADDR, input wire [31:0] DEST_ADDR, input wire [31:0] ERASE_BLOCK_SELECT_PARAM,
	input wire [7:0] KEY_REGISTER, input wire [7:0] ARRAY_SELECT_REG, input wire FLASH_ERROR_PROTECT_FLAG,
	input wire CELL_DONE, input wire CELL_FAIL, input wire REG_ALTERED, input wire [31:0] PASS_FAIL_RESULT,
	input wire RESULT_VALID, input wire CELL_PROG_GO, input wire CELL_ERASE_GO, input wire [3:0] ERASE_BLOCK_NUMBER
);
	wire p = PROG_START && !BUSY;
	wire e = ERASE_START && !PROG_START && !BUSY;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_fail_summary: assert property (RESULT_VALID |-> PASS_FAIL_RESULT[0] == |PASS_FAIL_RESULT[6:1]) else $error("sf");
	a_unused_zero: assert property (RESULT_VALID |-> PASS_FAIL_RESULT[31:7] == 0) else $error("unused");
	a_key_check: assert property (p && KEY_REGISTER != 8'h5A |=> RESULT_VALID && PASS_FAIL_RESULT[4]) else $error("fk");
	a_boot_array: assert property (p && ARRAY_SELECT_REG == 8'hAA |=> PASS_FAIL_RESULT[5] && !CELL_PROG_GO) else $error("boot");
	a_src_inside: assert property (p && SRC_DATA_ADDR < FLASH_SIZE |=> PASS_FAIL_RESULT[2]) else $error("wd");
	a_dst_outside: assert property (p && DEST_ADDR >= FLASH_SIZE |=> PASS_FAIL_RESULT[1]) else $error("wa");
	a_dst_align: assert property (p && DEST_ADDR[6:0] != 0 |=> PASS_FAIL_RESULT[1] && !CELL_PROG_GO) else $error("al");
	a_block_range: assert property (e && ERASE_BLOCK_SELECT_PARAM[7:0] > 8'h0B |=> !CELL_ERASE_GO) else $error("eb");
	a_block_take: assert property (CELL_ERASE_GO |-> ERASE_BLOCK_NUMBER == $past(ERASE_BLOCK_SELECT_PARAM[3:0])) else $error("n");
	a_exec_err: assert property (BUSY && CELL_DONE && (CELL_FAIL || REG_ALTERED) |=> PASS_FAIL_RESULT[5]) else $error("ee");
	a_mode_prot: assert property (p && FLASH_ERROR_PROTECT_FLAG |=> PASS_FAIL_RESULT[6]) else $error("md");
	a_fail_skip: assert property (p && KEY_REGISTER != 8'h5A |=> !CELL_PROG_GO && !BUSY) else $error("skip");
	a_erase_boot: assert property (e && ARRAY_SELECT_REG == 8'hAA |=> PASS_FAIL_RESULT[5] && !CELL_ERASE_GO) else $error("eboot");
	a_busy_go: assert property ((CELL_PROG_GO || CELL_ERASE_GO) |-> BUSY) else $error("busy");
endmodule // flash_param_checker
bind flash_prog_erase_param_check flash_param_checker #(.FLASH_SIZE(FLASH_SIZE)) flash_param_checker_i (.*);

//--- tb/cell_seq_model.sv
// Cell sequencer model: answers a go pulse with a done pulse.
// Assumes BAD is set before the go pulse.
`timescale 1ns/1ps
module cell_seq_model #(parameter DLY = 3) (input wire CLK, input wire GO, input wire [1:0] BAD,
	output reg DONE = 0, output reg FAIL = 0, output reg ALT = 0);
	integer n = 0;
	always @(posedge CLK) begin
		DONE <= (n == 1);
		FAIL <= (n == 1) ? BAD[0] : ~FAIL;
		ALT <= (n == 1) ? BAD[1] : ~ALT;
		n <= GO ? DLY : (n > 0 ? n - 1 : 0);
	end
endmodule // cell_seq_model

//--- tb/flash_prog_erase_param_check_tb.sv
// Self-checking bench for the flash parameter checker.
// Assumes the cell sequencer model answers the go pulses.
`timescale 1ns/1ps
module flash_prog_erase_param_check_tb;
	localparam [7:0] K = 8'h5A;
	localparam [31:0] S = 32'h00080000;
	reg CLK = 0, SRST = 1, PROG_START = 0, ERASE_START = 0, FLASH_WRITE_ENABLE_PIN = 1, FLASH_ERROR_PROTECT_FLAG = 0;
	reg [31:0] SRC_DATA_ADDR = S, DEST_ADDR = 0, ERASE_BLOCK_SELECT_PARAM = 0;
	reg [7:0] KEY_REGISTER = K, ARRAY_SELECT_REG = 0;
	reg [1:0] bad = 0;
	wire CELL_DONE, CELL_FAIL, REG_ALTERED, RESULT_VALID, BUSY, CELL_PROG_GO, CELL_ERASE_GO;
	wire [31:0] PASS_FAIL_RESULT;
	wire [3:0] ERASE_BLOCK_NUMBER;
	integer err_count = 0, checks = 0;
	flash_prog_erase_param_check flash_prog_erase_param_check_i (.*);
	cell_seq_model cell_seq_model_i (.CLK(CLK), .GO(CELL_PROG_GO | CELL_ERASE_GO), .BAD(bad),
		.DONE(CELL_DONE), .FAIL(CELL_FAIL), .ALT(REG_ALTERED));
	initial forever #12.5 CLK = ~CLK;
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	// Erase requests carry one block number in the low byte
	task go(input p, input [31:0] s, input [31:0] d, input [31:0] b, input [7:0] k, input [7:0] a, input [31:0] x);
		integer n;
		begin
			@(posedge CLK);
			SRC_DATA_ADDR <= s;
			DEST_ADDR <= d;
			ERASE_BLOCK_SELECT_PARAM <= b;
			KEY_REGISTER <= k;
			ARRAY_SELECT_REG <= a;
			PROG_START <= p;
			ERASE_START <= !p;
			@(posedge CLK);
			PROG_START <= 0;
			ERASE_START <= 0;
			n = 0;
			#1;
			while (RESULT_VALID !== 1'b1 && n < 40) begin
				@(posedge CLK);
				#1;
				n = n + 1;
			end
			chk(RESULT_VALID, 1'b1);
			chk(PASS_FAIL_RESULT, x);
		end
	endtask
	task t_prog;
		begin
			go(1, S, 0, 0, K, 0, 32'h0);
			bad <= 1;
			go(1, S, 32'h80, 0, K, 0, 32'h21);
			bad <= 2;
			go(1, S, 0, 0, K, 0, 32'h21);
			bad <= 0;
			$display("t_prog done");
		end
	endtask
	task t_errs;
		begin
			go(1, S, 0, 0, 8'h00, 0, 32'h11);
			go(1, 32'h100, 0, 0, K, 0, 32'h05);
			go(1, S, 32'h40, 0, K, 0, 32'h03);
			go(1, S, 32'h40000, 0, K, 0, 32'h03);
			go(1, S, 0, 0, K, 8'hAA, 32'h21);
			FLASH_ERROR_PROTECT_FLAG <= 1;
			go(1, S, 0, 0, K, 0, 32'h41);
			FLASH_ERROR_PROTECT_FLAG <= 0;
			FLASH_WRITE_ENABLE_PIN <= 0;
			repeat (6) @(posedge CLK);
			go(1, S, 0, 0, K, 0, 32'h41);
			FLASH_WRITE_ENABLE_PIN <= 1;
			repeat (6) @(posedge CLK);
			$display("t_errs done");
		end
	endtask
	task t_erase;
		begin
			go(0, S, 0, 32'h0B, K, 0, 32'h0);
			chk(ERASE_BLOCK_NUMBER, 4'hB);
			go(0, S, 0, 32'h100, K, 0, 32'h0);
			chk(ERASE_BLOCK_NUMBER, 4'h0);
			go(0, S, 0, 32'h0C, K, 0, 32'h09);
			go(0, S, 0, 32'hFF, K, 0, 32'h09);
			go(0, S, 0, 32'h01, K, 8'hAA, 32'h21);
			$display("t_erase done");
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", checks, err_count);
			if (err_count == 0 && checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	initial begin
		repeat (4) @(posedge CLK);
		SRST <= 0;
		repeat (6) @(posedge CLK);
		t_prog;
		t_errs;
		t_erase;
		tally_and_finish;
	end
	// Tests need under 2000 cycles
	initial begin
		#50000;
		err_count = err_count + 1;
		tally_and_finish;
	end
endmodule // flash_prog_erase_param_check_tb
